// ===== logic/epv_pkg.sv
// Package with constants for the program memory programming and lock block
package epv_pkg;
  localparam int EPV_AW = 12;  // Location address width
  localparam int EPV_DW = 8;   // Code byte width
  localparam int EPV_DEPTH = 4096;  // Locations in the array
  localparam logic [EPV_DW-1:0] EPV_ERASED = 8'hFF;  // Erased byte value
  localparam logic EPV_LOCK_ERASED = 1'b1;  // Erased lock reads as one
  // Clock rate and pulse timing
  localparam int EPV_CLK_HZ = 40000000;
  localparam int EPV_PULSE_MIN_MS = 45;  // Shortest program pulse
  localparam int EPV_PULSE_MAX_MS = 55;  // Longest program pulse
  localparam int EPV_PULSE_MIN_CYC = (EPV_CLK_HZ / 1000) * EPV_PULSE_MIN_MS;
  localparam int EPV_PULSE_MAX_CYC = (EPV_CLK_HZ / 1000) * EPV_PULSE_MAX_MS;
  localparam int EPV_CNT_W = 22;  // Wide enough for the long limit
  // Data valid and float delay, in device oscillator periods
  localparam int EPV_OSC_PERIODS = 48;
  localparam int EPV_OSC_MAX_HZ = 6000000;
  // Cycles at our clock for 48 oscillator periods at fastest oscillator, rounded down
  localparam int EPV_VALID_CYC = (EPV_OSC_PERIODS * EPV_CLK_HZ) / EPV_OSC_MAX_HZ;
  localparam int EPV_VCNT_W = 9;
  // Wishbone register map
  localparam logic [3:0] EPV_REG_STATUS = 4'h0;  // Lock, busy, last result
  localparam logic [3:0] EPV_REG_CTRL = 4'h4;    // Bit 0 writes 1 to erase array
  localparam int EPV_ST_LOCK = 0;
  localparam int EPV_ST_BUSY = 1;
  localparam int EPV_ST_WROTE = 2;
  localparam int EPV_ST_REFUSED = 3;
  localparam int EPV_ST_SHORT = 4;
  localparam int EPV_CTRL_ERASE = 0;
  typedef enum logic [1:0] {EPV_IDLE, EPV_PULSE, EPV_ERASE} epv_state_t;
endpackage

// ===== logic/epv_mem.sv
// Single-port program memory array with registered read data
`timescale 1ns/1ps
module epv_mem
  import epv_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [EPV_AW-1:0] i_addr,
  input wire logic [EPV_DW-1:0] i_wdata,
  output logic [EPV_DW-1:0] o_rdata
);
  logic [EPV_DW-1:0] mem_q [EPV_DEPTH];  // No reset: erasure is done by sweeping

  // Write port
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_q[i_addr] <= i_wdata;
    end
  end

  // Registered read
  always_ff @(posedge i_clk) begin
    o_rdata <= mem_q[i_addr];
  end
endmodule

// ===== logic/epv_top.sv
// Program memory programming, verification and security lock block
// Notes on behaviour
// - Program pulse low 45 to 55 ms writes
// - Verify drives addressed byte onto port 0
// - Verify strobe: valid, float within 48 periods
// - Readout only while lock unprogrammed
// - Lock refuses readout, programming, external fetch
// - Erasure sets all bits and lock to one
// - Latch strobe pin is program pulse input
`timescale 1ns/1ps
module epv_top
  import epv_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_rst_pin,                 // Device reset pin, high in all modes
  input wire logic i_code_store_strobe,       // Held low in programming modes
  input wire logic i_prog_pulse_n,            // Latch strobe pin used as pulse input
  input wire logic i_external_access_select,  // Logic high level
  input wire logic i_vpp_present,             // Programming voltage detected
  input wire logic i_verify_enable_line,
  input wire logic i_lock_select_line,
  input wire logic [7:0] i_port1,
  input wire logic [3:0] i_port2_low,
  input wire logic [7:0] i_port0,
  output logic [7:0] o_port0,
  output logic [7:0] o_port0_oe,
  output logic o_ext_fetch_allow,             // External code fetch permitted
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack
);
  // Three-stage synchronisers on pin inputs; bit order below
  localparam int NS = 27;  // Seven level pins, port 1, port 2 low nibble, port 0
  logic [NS-1:0] pins_raw;
  logic [NS-1:0] s1_q, s2_q, s3_q, pin_q;
  assign pins_raw = {i_rst_pin, i_code_store_strobe, i_prog_pulse_n,
    i_external_access_select, i_vpp_present, i_verify_enable_line,
    i_lock_select_line, i_port1, i_port2_low, i_port0};

  // Sync chain; stage one feeds only stage two
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pins_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept a bit only when stages two and three agree
  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_filt
      always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          pin_q[g] <= 1'b0;
        end else if (s2_q[g] == s3_q[g]) begin
          pin_q[g] <= s2_q[g];
        end
      end
    end
  endgenerate

  // Field views of the filtered pins
  logic rst_l, css_l, pulse_n_l, ea_l, vpp_l, ven_l, lck_l;
  logic [7:0] p1_l, p0_l;
  logic [3:0] p2_l;
  assign {rst_l, css_l, pulse_n_l, ea_l, vpp_l, ven_l, lck_l, p1_l, p2_l, p0_l} = pin_q;

  // Common programming level check: reset high, store strobe low
  function automatic logic base_ok(input logic r, input logic c);
    base_ok = r && !c;
  endfunction

  logic prog_mode, lock_mode, verify_mode;
  assign prog_mode = base_ok(rst_l, css_l) && ven_l && !lck_l && vpp_l;
  assign lock_mode = base_ok(rst_l, css_l) && ven_l && lck_l && vpp_l;
  assign verify_mode = base_ok(rst_l, css_l) && !ven_l && !lck_l && ea_l && !vpp_l;

  // State, counters and flags
  epv_state_t state_q;
  logic [EPV_CNT_W-1:0] pcnt_q;
  logic [EPV_AW-1:0] ecnt_q, addr_q;
  logic [EPV_DW-1:0] data_q;
  logic was_lock_q;
  logic lock_q;            // One means unprogrammed
  logic wrote_q, refused_q, short_q;
  logic erase_req;
  logic [EPV_DW-1:0] rdata;
  logic mem_we;
  logic [EPV_AW-1:0] mem_addr;
  logic [EPV_DW-1:0] mem_wd;
  logic pulse_end, pulse_ok;

  assign pulse_end = (state_q == EPV_PULSE) && pulse_n_l;
  // Pulse shorter than minimum or over maximum is not accepted
  assign pulse_ok = (pcnt_q >= EPV_CNT_W'(EPV_PULSE_MIN_CYC))
    && (pcnt_q <= EPV_CNT_W'(EPV_PULSE_MAX_CYC));

  // Memory port steering: erase sweep, pulse end write, else verify address
  always_comb begin
    mem_we = 1'b0;
    mem_addr = {p2_l, p1_l};
    mem_wd = data_q;
    if (state_q == EPV_ERASE) begin
      mem_we = 1'b1;
      mem_addr = ecnt_q;
      mem_wd = EPV_ERASED;
    end else if (pulse_end && pulse_ok && !was_lock_q && lock_q) begin
      mem_we = 1'b1;
      mem_addr = addr_q;
    end
  end

  epv_mem u_mem (
    .i_clk(i_clk),
    .i_we(mem_we),
    .i_addr(mem_addr),
    .i_wdata(mem_wd),
    .o_rdata(rdata)
  );

  // Program pulse sequencer; pulse arrives on latch strobe pin
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= EPV_IDLE;
      pcnt_q <= '0;
      addr_q <= '0;
      data_q <= '0;
      was_lock_q <= 1'b0;
    end else begin
      unique case (state_q)
        EPV_IDLE: begin
          if (erase_req) begin
            state_q <= EPV_ERASE;
          end else if (!pulse_n_l && (prog_mode || lock_mode)) begin
            // Capture at falling edge; setup was met by programmer
            state_q <= EPV_PULSE;
            pcnt_q <= '0;
            addr_q <= {p2_l, p1_l};
            data_q <= p0_l;
            was_lock_q <= lock_mode;
          end
        end
        EPV_PULSE: begin
          if (pulse_n_l) begin
            state_q <= EPV_IDLE;
          end else if (pcnt_q != '1) begin
            pcnt_q <= pcnt_q + 1'b1;  // Saturate to flag overlong pulses
          end
        end
        EPV_ERASE: begin
          if (ecnt_q == '1) begin
            state_q <= EPV_IDLE;
          end
        end
        // Unused fourth code falls back to idle
        default: begin
          state_q <= EPV_IDLE;
        end
      endcase
    end
  end

  // Erase sweep address
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ecnt_q <= '0;
    end else if (state_q == EPV_ERASE) begin
      ecnt_q <= ecnt_q + 1'b1;
    end else begin
      ecnt_q <= '0;
    end
  end

  // Lock bit: set by lock pulse, cleared only by erasure or reset
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lock_q <= EPV_LOCK_ERASED;
    end else if (pulse_end && pulse_ok && was_lock_q) begin
      lock_q <= 1'b0;
    end else if (state_q == EPV_ERASE && ecnt_q == '1) begin
      lock_q <= EPV_LOCK_ERASED;
    end
  end

  // Result flags of the last pulse
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wrote_q <= 1'b0;
      refused_q <= 1'b0;
      short_q <= 1'b0;
    end else if (pulse_end) begin
      wrote_q <= pulse_ok && (was_lock_q || lock_q);
      refused_q <= !was_lock_q && !lock_q;
      short_q <= !pulse_ok;
    end
  end

  // Verify output: drive while verifying unlocked, float on the sixth clock edge after strobe goes high
  logic ven_q;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ven_q <= 1'b0;
    end else if (verify_mode && lock_q && state_q == EPV_IDLE) begin
      // Data is ready well inside the allowed window
      ven_q <= 1'b1;
    end else begin
      ven_q <= 1'b0;
    end
  end

  // Port 0 drivers, open drain: drive only zero bits, pullups give ones
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_port0 <= '0;
      o_port0_oe <= '0;
    end else if (ven_q) begin
      o_port0 <= '0;
      o_port0_oe <= ~rdata;
    end else begin
      o_port0 <= '0;
      o_port0_oe <= '0;
    end
  end

  // External fetch allowed only while unlocked
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ext_fetch_allow <= 1'b0;
    end else begin
      o_ext_fetch_allow <= lock_q;
    end
  end

  // Wishbone slave, one wait cycle, ack drops after one cycle
  logic wb_req;
  assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign erase_req = wb_req && i_wb_we && (i_wb_adr == EPV_REG_CTRL) && i_wb_sel[0]
    && i_wb_dat[EPV_CTRL_ERASE] && (state_q == EPV_IDLE);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= '0;
    end else begin
      o_wb_ack <= wb_req;
      o_wb_dat <= '0;
      if (wb_req && !i_wb_we && i_wb_adr == EPV_REG_STATUS) begin
        o_wb_dat[EPV_ST_LOCK] <= lock_q;
        o_wb_dat[EPV_ST_BUSY] <= (state_q != EPV_IDLE);
        o_wb_dat[EPV_ST_WROTE] <= wrote_q;
        o_wb_dat[EPV_ST_REFUSED] <= refused_q;
        o_wb_dat[EPV_ST_SHORT] <= short_q;
      end
    end
  end
endmodule

// ===== tb/epv_top_sva.sv
// Port assertions for the programming and lock block
`timescale 1ns/1ps
module epv_sva_chk
  import epv_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_verify_enable_line,
  input wire logic i_prog_pulse_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [7:0] o_port0,
  input wire logic [7:0] o_port0_oe,
  input wire logic o_ext_fetch_allow,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // Every new bus request gets its answer one cycle later
  ack_resp_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("request without answer");
  ack_drop_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("answer longer than one cycle");
  // Only a status read carries data
  dat_zero_a: assert property (o_wb_ack && $past(i_wb_we || i_wb_adr != EPV_REG_STATUS)
    |-> o_wb_dat == 32'h0) else $error("data on a non status answer");
  drive_zero_a: assert property (o_port0 == 8'h00)
    else $error("data port driven high");
  // Filter and release take under ten cycles, far inside the float bound
  float_a: assert property (i_verify_enable_line [*8] |-> ##2 o_port0_oe == 8'h00)
    else $error("data port still driven after verify");
  locked_quiet_a: assert property (!o_ext_fetch_allow |-> o_port0_oe == 8'h00)
    else $error("readout while locked");
  inhibit_a: assert property (i_prog_pulse_n [*8] |=> !$fell(o_ext_fetch_allow))
    else $error("lock set without pulse");
  status_lock_a: assert property (o_wb_ack && $past(!i_wb_we && i_wb_adr == EPV_REG_STATUS)
    |-> o_wb_dat[EPV_ST_LOCK] == o_ext_fetch_allow) else $error("lock status mismatch");
  cover property (o_wb_ack && o_wb_dat[EPV_ST_BUSY]);
  cover property (!i_prog_pulse_n);
  cover property (i_verify_enable_line [*8]);
endmodule

bind epv_top epv_sva_chk u_chk (.*);

// ===== tb/epv_prog_model.sv
// Programmer model setting the pin levels of each mode
`timescale 1ns/1ps
module epv_prog_model
  import epv_pkg::*;
(
  input wire logic [1:0] i_mode,  // 0 verify, 1 program, 2 lock
  input wire logic i_pulse_n,
  input wire logic [11:0] i_addr,
  input wire logic [7:0] i_data,
  input wire logic [7:0] i_port0_oe,
  input wire logic [7:0] i_port0_val,
  output logic o_rst_pin,
  output logic o_strobe,
  output logic o_pulse_n,
  output logic o_ea,
  output logic o_vpp,
  output logic o_verify,
  output logic o_lock,
  output logic [7:0] o_port1,
  output logic [3:0] o_port2_low,
  output logic [7:0] o_port0
);
  // Levels common to every mode
  assign o_rst_pin = 1'b1;
  assign o_strobe = 1'b0;
  assign o_ea = 1'b1;
  // Supply only around writes; verify needs it off
  assign o_vpp = (i_mode != 2'h0);
  assign o_verify = (i_mode != 2'h0);
  assign o_lock = (i_mode == 2'h2);
  assign o_pulse_n = i_pulse_n;
  assign o_port1 = i_addr[7:0];
  assign o_port2_low = i_addr[11:8];
  // Released bits float up through the pull-ups, except in mode 1 where they carry the data byte
  assign o_port0 = (i_port0_oe & i_port0_val)
    | (~i_port0_oe & ((i_mode == 2'h1) ? i_data : 8'hFF));
endmodule

// ===== tb/eprom_program_verify_lock_test.sv
// Self-checking bench for the programming and lock block
`timescale 1ns/1ps
module eprom_program_verify_lock_test
  import epv_pkg::*;
;
  logic i_clk = 0, i_nrst = 0, cyc = 0, stb = 0, we = 0, pn = 1;
  logic [1:0] mode = 2'h0;
  logic [3:0] adr = 4'h0, sel = 4'h0, p2;
  logic [11:0] addr = 12'h000;
  logic [7:0] data = 8'h00, p1, p0, oe, pv;
  logic [31:0] wdat = 32'h0, q, rdat;
  logic rst_pin, strobe, pulse, ea, vpp, ver, lck, fa, ack;
  int n_fail = 0, checks = 0, cyc_n = 0;
  epv_prog_model u_prog (.i_mode(mode), .i_pulse_n(pn), .i_addr(addr), .i_data(data),
    .i_port0_oe(oe), .i_port0_val(pv), .o_rst_pin(rst_pin), .o_strobe(strobe),
    .o_pulse_n(pulse), .o_ea(ea), .o_vpp(vpp), .o_verify(ver), .o_lock(lck),
    .o_port1(p1), .o_port2_low(p2), .o_port0(p0));
  epv_top u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_rst_pin(rst_pin),
    .i_code_store_strobe(strobe), .i_prog_pulse_n(pulse), .i_external_access_select(ea),
    .i_vpp_present(vpp), .i_verify_enable_line(ver), .i_lock_select_line(lck),
    .i_port1(p1), .i_port2_low(p2), .i_port0(p0), .o_port0(pv), .o_port0_oe(oe),
    .o_ext_fetch_allow(fa), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack));
  initial forever #12.5 i_clk = ~i_clk;
  task automatic give_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Whole run needs well under this many cycles
  always @(posedge i_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 12000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One classic cycle; ack is read before this edge's updates land
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    do @(posedge i_clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Pin levels need filtering, so let them settle
  task automatic look(input logic [1:0] m, input logic [11:0] a);
    @(posedge i_clk);
    mode <= m;
    addr <= a;
    repeat (12) @(posedge i_clk);
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    wb(1'b0, EPV_REG_STATUS, 32'h0);
    chk(q & 32'h1F, 32'h01);
    chk({31'h0, fa}, 32'h1);
    wb(1'b1, 4'hC, 32'hFFFF_FFFF);
    wb(1'b0, 4'hC, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, EPV_REG_CTRL, 32'h1);
    wb(1'b0, EPV_REG_STATUS, 32'h0);
    chk({31'h0, q[EPV_ST_BUSY]}, 32'h1);
    do wb(1'b0, EPV_REG_STATUS, 32'h0); while (q[EPV_ST_BUSY] !== 1'b0);
    chk(q & 32'h1F, 32'h01);
    for (int i = 0; i < 8; i++) begin
      look(2'h0, {i[3:0], 8'h5A} ^ 12'hA5F);
      chk({24'h0, p0}, 32'hFF);
    end
    look(2'h1, 12'h123);
    repeat (200) @(posedge i_clk);
    look(2'h0, 12'h123);
    chk({24'h0, p0}, 32'hFF);
    data <= 8'h3C;
    look(2'h1, 12'h0A0);
    repeat (EPV_VALID_CYC) @(posedge i_clk);
    pn <= 1'b0;
    repeat (1000) @(posedge i_clk);
    pn <= 1'b1;
    repeat (EPV_VALID_CYC) @(posedge i_clk);
    look(2'h0, 12'h0A0);
    wb(1'b0, EPV_REG_STATUS, 32'h0);
    chk(q & 32'h1C, 32'h10);
    chk({24'h0, p0}, 32'hFF);
    give_verdict();
  end
endmodule
